// ===== tb/jtb_tap_boundary_scan_tb_top.sv
// Self-checking bench for the boundary-scan test access port
module jtb_tap_boundary_scan_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BL = 8; // Boundary register length
  // Identification fields; values are arbitrary
  localparam logic [3:0] VER = 4'h3;
  localparam logic [15:0] PRT = 16'hC3A5;
  localparam logic [10:0] MFG = 11'h2B4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  jtb_pkg::jtb_pins_t tap;
  jtb_pkg::jtb_tdo_t tdo;
  logic [BL-1:0] pin_in = 8'h3C;
  logic [BL-1:0] sys_out = 8'h96;
  logic [BL-1:0] sys_oe = 8'hF0;
  logic [BL-1:0] pout;
  logic [BL-1:0] poe;
  logic [2:0] instr;
  int num_errors = 0;
  int cmp_count = 0;

  always #4 clk = ~clk;

  jtb_tap #(.BSR_LEN(BL), .ID_VERSION(VER), .ID_PART(PRT),
    .ID_MANUF(MFG)) u_dut (.i_core_clk(clk), .i_rstn(rstn),
    .i_tap(tap), .i_pin_in(pin_in), .i_sys_out(sys_out),
    .i_sys_oe(sys_oe), .o_pin_out(pout), .o_pin_oe(poe),
    .o_tdo(tdo), .o_instr(instr));
  jtb_tester u_tester (.i_tdo(tdo), .o_pins(tap));

  ////////////////////////////////////////////////////////////////////////
  // Compare one value and count it
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Start link activity between core edges, never on one
  task automatic link_start();
    @(posedge clk) #1.3;
  endtask

  // Verdict and end of run
  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Scan from idle back to idle, optional pause after bit pz
  task automatic scan(input bit ir, input int n, input logic [31:0] din,
                      input int pz, output logic [31:0] dout);
    logic t;
    dout = '0;
    u_tester.step(1'b1, 1'b0, t);
    if (ir)
      u_tester.step(1'b1, 1'b0, t);
    u_tester.step(1'b0, 1'b0, t);
    u_tester.step(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++)
    begin
      u_tester.step(i == n - 1 || i == pz, din[i], t);
      dout[i] = t;
      // Pause, stay, exit2, back to shift
      if (i == pz)
      begin
        u_tester.step(1'b0, 1'b0, t);
        u_tester.step(1'b0, 1'b0, t);
        u_tester.step(1'b1, 1'b0, t);
        u_tester.step(1'b0, 1'b0, t);
      end
    end
    u_tester.step(1'b1, 1'b0, t);
    u_tester.step(1'b0, 1'b0, t);
  endtask

  // Load one instruction and check capture pattern
  task automatic load_ir(input logic [2:0] code, input int pz);
    logic [31:0] o;
    scan(1'b1, 3, {29'h0, code}, pz, o);
    cmp(o[2:0], 3'h1);
    cmp(instr, code);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Identification read straight after reset
  task automatic t_idcode();
    logic [31:0] o;
    logic t;
    cmp(instr, 3'h1);
    cmp(tdo.oe, 1'b0);
    u_tester.step(1'b0, 1'b0, t);
    scan(1'b0, 32, 32'h0, -1, o);
    cmp(o, {VER, PRT, MFG, 1'b1});
    cmp(tdo.oe, 1'b0);
  endtask

  // Codes 0 to 4 and 7, some with an instruction pause
  task automatic t_codes();
    logic [2:0] c [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    for (int k = 0; k < 6; k++)
    begin
      load_ir(c[k], k % 3 - 1);
      cmp(poe, c[k] == 3'h4 ? 8'h00 :
        (c[k] == 3'h0 || c[k] == 3'h3) ? 8'hFF : sys_oe);
    end
  endtask

  // Sample, preload, drive, recapture, clamp
  task automatic t_boundary();
    logic [31:0] o;
    load_ir(3'h2, -1);
    scan(1'b0, BL, 32'hA6, 3, o);
    cmp(o, pin_in);
    cmp(pout, sys_out);
    load_ir(3'h0, -1);
    cmp(pout, 8'hA6);
    @(posedge clk) #1 pin_in = 8'hC1;
    link_start();
    scan(1'b0, BL, 32'h5B, -1, o);
    cmp(o, 8'hC1);
    cmp(pout, 8'h5B);
    load_ir(3'h3, -1);
    scan(1'b0, BL, 32'h0F, -1, o);
    cmp(pout, 8'h5B);
  endtask

  // One-stage bypass under codes 3, 4, 5 and 7
  task automatic t_bypass();
    logic [2:0] c [4] = '{3'h3, 3'h4, 3'h5, 3'h7};
    logic [31:0] o;
    for (int k = 0; k < 4; k++)
    begin
      load_ir(c[k], -1);
      scan(1'b0, BL, 32'h9D, -1, o);
      cmp(o, 8'h3A);
    end
    @(posedge clk) #1 sys_out = 8'h4E;
    @(posedge clk) #1;
    cmp(pout, 8'h4E);
    link_start();
  endtask

  // Test reset mid-shift, then five highs
  task automatic t_resets();
    logic t;
    u_tester.step(1'b1, 1'b0, t);
    u_tester.step(1'b0, 1'b0, t);
    u_tester.step(1'b0, 1'b0, t);
    u_tester.step(1'b0, 1'b1, t);
    u_tester.pulse_reset();
    cmp(instr, 3'h1);
    cmp(tdo.oe, 1'b0);
    u_tester.step(1'b0, 1'b0, t);
    load_ir(3'h7, -1);
    repeat (5) u_tester.step(1'b1, 1'b0, t);
    cmp(instr, 3'h1);
    u_tester.step(1'b0, 1'b0, t);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    link_start();
    t_idcode();
    t_codes();
    t_boundary();
    t_bypass();
    t_resets();
    conclude();
  end

  // Hang guard
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule // jtb_tap_boundary_scan_tb_top

// ===== tb/jtb_tap_properties.sv
// Concurrent checks on the test access port outputs
module jtb_tap_properties #(
  parameter int BSR_LEN = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire jtb_pkg::jtb_pins_t i_tap,
  input wire logic [BSR_LEN-1:0] i_pin_in,
  input wire logic [BSR_LEN-1:0] i_sys_out,
  input wire logic [BSR_LEN-1:0] i_sys_oe,
  input wire logic [BSR_LEN-1:0] o_pin_out,
  input wire logic [BSR_LEN-1:0] o_pin_oe,
  input wire jtb_pkg::jtb_tdo_t o_tdo,
  input wire logic [jtb_pkg::IR_W-1:0] o_instr
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  logic tck_d_r; // Test clock one cycle ago
  logic [2:0] hi_cnt_r; // Rises seen with mode select high
  logic [1:0] clp_cnt_r; // Cycles spent under clamp
  logic nrm; // Pins left to the system
  logic tst; // Pins driven from boundary latches
  logic quiet; // No test reset recently

  assign nrm = !(o_instr inside {3'h0, 3'h3, 3'h4});
  assign tst = o_instr inside {3'h0, 3'h3};

  ////////////////////////////////////////////////////////////////////////
  // Count mode-select-high rises; any reset counts as five
  always_ff @(posedge i_core_clk)
  begin
    tck_d_r <= i_tap.test_clock_pin;
    if (!i_rstn || !i_tap.test_reset_n_pin)
      hi_cnt_r <= 3'h5;
    else if (i_tap.test_clock_pin && !tck_d_r)
      hi_cnt_r <= !i_tap.test_mode_select_pin ? 3'h0 :
        (hi_cnt_r == 3'h5 ? 3'h5 : hi_cnt_r + 3'h1);
  end

  // Age of the clamp instruction, saturating
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn || o_instr != 3'h3)
      clp_cnt_r <= 2'h0;
    else if (clp_cnt_r != 2'h3)
      clp_cnt_r <= clp_cnt_r + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Test reset held long enough to pass the synchroniser
  sequence s_trst_low;
    !i_tap.test_reset_n_pin [*4];
  endsequence

  sequence s_calm;
    $past(i_rstn) && i_tap.test_reset_n_pin &&
      $past(i_tap.test_reset_n_pin, 5);
  endsequence

  chk_reset_vals: assert property (
    $rose(i_rstn) |-> o_instr == 3'h1 && o_tdo == 2'h0)
    else $error("Bad outputs after reset");
  chk_trst_force: assert property (
    s_trst_low |=> o_instr == 3'h1 && !o_tdo.oe)
    else $error("Test reset did not force idcode");
  chk_five_highs: assert property (
    hi_cnt_r == 3'h5 |-> ##[0:8] o_instr == 3'h1)
    else $error("Five highs did not reach reset");
  chk_pins_follow: assert property (
    $past(i_rstn) && nrm && $past(nrm) |->
      o_pin_out == $past(i_sys_out) && o_pin_oe == $past(i_sys_oe))
    else $error("Pins do not follow system");
  chk_highz_float: assert property (
    o_instr == 3'h4 && $past(o_instr) == 3'h4 |-> o_pin_oe == '0)
    else $error("Pins driven under highz");
  chk_test_drive: assert property (
    tst && $past(tst) |-> o_pin_oe == '1)
    else $error("Pins not driven under test");
  chk_clamp_hold: assert property (
    clp_cnt_r == 2'h3 && o_instr == 3'h3 |-> $stable(o_pin_out))
    else $error("Pins moved under clamp");
  chk_tdo_on_fall: assert property (
    s_calm and $changed(o_tdo) |->
      !i_tap.test_clock_pin && !$past(i_tap.test_clock_pin, 3))
    else $error("Data out moved off a falling edge");
  chk_instr_on_fall: assert property (
    s_calm and $changed(o_instr) && o_instr != 3'h1 |->
      !i_tap.test_clock_pin && !$past(i_tap.test_clock_pin, 3))
    else $error("Instruction latched off a falling edge");
endmodule // jtb_tap_properties

bind jtb_tap jtb_tap_properties #(.BSR_LEN(BSR_LEN)) u_props (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_tap(i_tap),
  .i_pin_in(i_pin_in), .i_sys_out(i_sys_out), .i_sys_oe(i_sys_oe),
  .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_tdo(o_tdo),
  .o_instr(o_instr));

// ===== tb/jtb_tester.sv
// Behavioural boundary-scan tester driving the test pins
module jtb_tester (
  input wire jtb_pkg::jtb_tdo_t i_tdo,
  output jtb_pkg::jtb_pins_t o_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5; // Half test clock period
  logic last_r = 1'b0; // Last level actually driven
  logic tdo_w; // Level seen on the data out wire

  // Released wire shows the inverse of its last driven level
  always @(i_tdo)
    if (i_tdo.oe)
      last_r = i_tdo.dat;
  assign tdo_w = i_tdo.oe ? i_tdo.dat : ~last_r;

  // Test reset inactive, clock parked low between frames
  initial o_pins = 4'h8;

  // mode select set before each rise
  task automatic step(input logic tms, input logic tdi,
                      output logic tdo);
    o_pins.test_mode_select_pin = tms;
    o_pins.test_data_in_pin = tdi;
    #(HALF);
    tdo = tdo_w;
    o_pins.test_clock_pin = 1'b1;
    #(HALF);
    o_pins.test_clock_pin = 1'b0;
  endtask

  // test reset pulse, clock standing still
  task automatic pulse_reset();
    o_pins.test_reset_n_pin = 1'b0;
    #(HALF * 4);
    o_pins.test_reset_n_pin = 1'b1;
    #(HALF);
  endtask
endmodule // jtb_tester

// ===== verilog/jtb_pkg.sv
// Shared constants, states and carrier types of the test access port
package jtb_pkg;

  // Instruction register width and codes
  localparam int IR_W = 3;
  localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE = 3'h2;
  localparam logic [IR_W-1:0] INS_CLAMP = 3'h3;
  localparam logic [IR_W-1:0] INS_HIGHZ = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
  // Fixed capture value, shows 1 then 0 first on data out
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

  // Identification register layout
  localparam int ID_W = 32;
  localparam int ID_VER_W = 4;
  localparam int ID_PART_W = 16;
  localparam int ID_MANUF_W = 11;
  localparam logic ID_LSB = 1'h1;

  // Synchroniser depth and reset values
  localparam int SYNC_STAGES = 2;
  localparam logic BYP_CAPTURE = 1'h0;
  localparam logic TDO_IDLE = 1'h0;

  // Sixteen controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
    ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
    ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } jtb_state_t;

  // Test pins coming from the tester
  typedef struct packed {
    logic test_reset_n_pin;
    logic test_clock_pin;
    logic test_mode_select_pin;
    logic test_data_in_pin;
  } jtb_pins_t;

  // Test data out pin, value and enable
  typedef struct packed {
    logic dat;
    logic oe;
  } jtb_tdo_t;

endpackage

// ===== verilog/jtb_sync.sv
// Two-stage level synchroniser, one chain per bit
module jtb_sync #(
  parameter int W = 1
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  ////////////////////////////////////////////////////////////////////////
  // One chain per bit; first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic meta_r;
      logic hold_r;
      // First and second stage
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rstn)
        begin
          meta_r <= 1'h0;
          hold_r <= 1'h0;
        end
        else
        begin
          meta_r <= i_async[g];
          hold_r <= meta_r;
        end
      end
      assign o_sync[g] = hold_r;
    end
  endgenerate

endmodule // jtb_sync

// ===== verilog/jtb_tap.sv
// Boundary-scan test access port controller with its test registers

module jtb_tap #(
  parameter int BSR_LEN = 8,
  // Identification fields; values are arbitrary
  parameter logic [3:0] ID_VERSION = 4'h1,
  parameter logic [15:0] ID_PART = 16'h5A5A,
  parameter logic [10:0] ID_MANUF = 11'h123
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire jtb_pkg::jtb_pins_t i_tap,
  input wire logic [BSR_LEN-1:0] i_pin_in,
  input wire logic [BSR_LEN-1:0] i_sys_out,
  input wire logic [BSR_LEN-1:0] i_sys_oe,
  output logic [BSR_LEN-1:0] o_pin_out,
  output logic [BSR_LEN-1:0] o_pin_oe,
  output jtb_pkg::jtb_tdo_t o_tdo,
  output logic [jtb_pkg::IR_W-1:0] o_instr
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  // Synchronised test pins
  jtb_pkg::jtb_pins_t tap_s;
  // Synchronised device pin inputs
  logic [BSR_LEN-1:0] pin_s;
  // Delayed test clock for edge finding
  logic tck_d_r;
  // Test clock edges, one core cycle each
  logic tck_rise;
  logic tck_fall;
  // Synchronised test reset, active low
  logic trst_n;
  // Controller state
  jtb_pkg::jtb_state_t state_r;
  jtb_pkg::jtb_state_t state_nxt;
  logic [jtb_pkg::IR_W-1:0] ir_sh_r;
  logic [jtb_pkg::IR_W-1:0] instr_r;
  // Bypass stage
  logic byp_r;
  // Identification shift stages and latch
  logic [jtb_pkg::ID_W-1:0] id_sh_r;
  logic [jtb_pkg::ID_W-1:0] id_upd_r;
  // Boundary-scan shift stages and latch
  logic [BSR_LEN-1:0] bsr_sh_r;
  logic [BSR_LEN-1:0] bsr_upd_r;
  // Register selection by current instruction
  logic sel_bsr;
  logic sel_id;
  // Pins driven from boundary latches
  logic ext_drive;
  // Full identification code
  logic [jtb_pkg::ID_W-1:0] id_code;
  // Serial value for data out
  logic tdo_nxt;
  // Output flops
  logic [BSR_LEN-1:0] pin_out_r;
  logic [BSR_LEN-1:0] pin_oe_r;
  jtb_pkg::jtb_tdo_t tdo_r;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Test pins pass two flops first
  jtb_sync #(
    .W($bits(jtb_pkg::jtb_pins_t))
  ) u_sync_tap (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_async(i_tap),
    .o_sync(tap_s)
  );

  // Device pin inputs pass two flops too
  jtb_sync #(
    .W(BSR_LEN)
  ) u_sync_pin (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_async(i_pin_in),
    .o_sync(pin_s)
  );

  assign trst_n = tap_s.test_reset_n_pin;

  ////////////////////////////////////////////////////////////////////////
  // Test clock edge detection

  // Delay stage of the synchronised clock
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      tck_d_r <= 1'h0;
    else
      tck_d_r <= tap_s.test_clock_pin;
  end

  assign tck_rise = tap_s.test_clock_pin & ~tck_d_r;
  assign tck_fall = ~tap_s.test_clock_pin & tck_d_r;

  ////////////////////////////////////////////////////////////////////////
  // Instruction decode

  assign sel_bsr = (instr_r == jtb_pkg::INS_EXTEST) ||
                   (instr_r == jtb_pkg::INS_SAMPLE);
  assign sel_id = (instr_r == jtb_pkg::INS_IDCODE) ||
                  (state_r == jtb_pkg::ST_RESET);
  // EXTEST and CLAMP drive from latches
  assign ext_drive = (instr_r == jtb_pkg::INS_EXTEST) ||
                     (instr_r == jtb_pkg::INS_CLAMP);

  assign id_code = {ID_VERSION, ID_PART, ID_MANUF, jtb_pkg::ID_LSB};

  ////////////////////////////////////////////////////////////////////////
  // Next state on mode select

  // Transition table of the sixteen states
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      jtb_pkg::ST_RESET:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_RESET
                                              : jtb_pkg::ST_IDLE;
      jtb_pkg::ST_IDLE:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_SEL_DR
                                              : jtb_pkg::ST_IDLE;
      jtb_pkg::ST_SEL_DR:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_SEL_IR
                                              : jtb_pkg::ST_CAP_DR;
      jtb_pkg::ST_CAP_DR:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_EX1_DR
                                              : jtb_pkg::ST_SH_DR;
      jtb_pkg::ST_SH_DR:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_EX1_DR
                                              : jtb_pkg::ST_SH_DR;
      jtb_pkg::ST_EX1_DR:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_UPD_DR
                                              : jtb_pkg::ST_PAU_DR;
      jtb_pkg::ST_PAU_DR:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_EX2_DR
                                              : jtb_pkg::ST_PAU_DR;
      jtb_pkg::ST_EX2_DR:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_UPD_DR
                                              : jtb_pkg::ST_SH_DR;
      jtb_pkg::ST_UPD_DR:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_SEL_DR
                                              : jtb_pkg::ST_IDLE;
      // instruction scan or back to reset
      jtb_pkg::ST_SEL_IR:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_RESET
                                              : jtb_pkg::ST_CAP_IR;
      jtb_pkg::ST_CAP_IR:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_EX1_IR
                                              : jtb_pkg::ST_SH_IR;
      jtb_pkg::ST_SH_IR:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_EX1_IR
                                              : jtb_pkg::ST_SH_IR;
      // pause on low, update on high
      jtb_pkg::ST_EX1_IR:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_UPD_IR
                                              : jtb_pkg::ST_PAU_IR;
      jtb_pkg::ST_PAU_IR:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_EX2_IR
                                              : jtb_pkg::ST_PAU_IR;
      jtb_pkg::ST_EX2_IR:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_UPD_IR
                                              : jtb_pkg::ST_SH_IR;
      // idle on low, select data on high
      jtb_pkg::ST_UPD_IR:
        state_nxt = tap_s.test_mode_select_pin ? jtb_pkg::ST_SEL_DR
                                              : jtb_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Controller state register

  // Moves on test clock rise; test reset forces the reset state at any time
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      state_r <= jtb_pkg::ST_RESET;
    else if (!trst_n)
      state_r <= jtb_pkg::ST_RESET;
    else if (tck_rise)
      state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Instruction shift stages

  // Capture fixed value, shift toward output
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      ir_sh_r <= jtb_pkg::IR_CAPTURE;
    else if (tck_rise)
    begin
      if (state_r == jtb_pkg::ST_CAP_IR)
        ir_sh_r <= jtb_pkg::IR_CAPTURE;
      else if (state_r == jtb_pkg::ST_SH_IR)
        ir_sh_r <= {tap_s.test_data_in_pin,
                    ir_sh_r[jtb_pkg::IR_W-1:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Latched instruction

  // Loads on fall in Update-IR; reset state or test reset forces IDCODE
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      instr_r <= jtb_pkg::INS_IDCODE;
    else if (!trst_n || state_r == jtb_pkg::ST_RESET)
      instr_r <= jtb_pkg::INS_IDCODE;
    // latch on falling edge, becomes current
    else if (tck_fall && state_r == jtb_pkg::ST_UPD_IR)
      instr_r <= ir_sh_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bypass stage

  // Single stage between data in and out
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      byp_r <= jtb_pkg::BYP_CAPTURE;
    else if (tck_rise && !sel_bsr && !sel_id)
    begin
      // Captures zero like any bypass stage
      if (state_r == jtb_pkg::ST_CAP_DR)
        byp_r <= jtb_pkg::BYP_CAPTURE;
      else if (state_r == jtb_pkg::ST_SH_DR)
        byp_r <= tap_s.test_data_in_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Identification register

  // Shift stages, selected by IDCODE
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      id_sh_r <= '0;
    else if (tck_rise && sel_id)
    begin
      if (state_r == jtb_pkg::ST_CAP_DR)
        id_sh_r <= id_code;
      else if (state_r == jtb_pkg::ST_SH_DR)
        id_sh_r <= {tap_s.test_data_in_pin,
                    id_sh_r[jtb_pkg::ID_W-1:1]};
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      id_upd_r <= '0;
    else if (tck_fall && sel_id && state_r == jtb_pkg::ST_UPD_DR)
      id_upd_r <= id_sh_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Boundary-scan register

  // Shift stages, selected by EXTEST or SAMPLE
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      bsr_sh_r <= '0;
    else if (tck_rise && sel_bsr)
    begin
      if (state_r == jtb_pkg::ST_CAP_DR)
        bsr_sh_r <= pin_s;
      else if (state_r == jtb_pkg::ST_SH_DR)
        bsr_sh_r <= {tap_s.test_data_in_pin,
                     bsr_sh_r[BSR_LEN-1:1]};
    end
  end

  // copy on fall in Update-DR only
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      bsr_upd_r <= '0;
    else if (tck_fall && sel_bsr && state_r == jtb_pkg::ST_UPD_DR)
      bsr_upd_r <= bsr_sh_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Device output pins

  // System values unless a test instruction owns the pins
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
    begin
      pin_out_r <= '0;
      pin_oe_r <= '0;
    end
    else if (instr_r == jtb_pkg::INS_HIGHZ)
    begin
      pin_out_r <= i_sys_out;
      pin_oe_r <= '0;
    end
    else if (ext_drive)
    begin
      pin_out_r <= bsr_upd_r;
      pin_oe_r <= '1;
    end
    else
    begin
      pin_out_r <= i_sys_out;
      pin_oe_r <= i_sys_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial data out

  // Output stage of the register in the path
  always_comb
  begin
    if (state_r == jtb_pkg::ST_SH_IR)
      tdo_nxt = ir_sh_r[0];
    else if (sel_id)
      tdo_nxt = id_sh_r[0];
    else if (sel_bsr)
      tdo_nxt = bsr_sh_r[0];
    else
      tdo_nxt = byp_r;
  end

  // changes on fall, driven only while shifting
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn || !trst_n)
    begin
      tdo_r.dat <= jtb_pkg::TDO_IDLE;
      tdo_r.oe <= 1'h0;
    end
    else if (tck_fall)
    begin
      tdo_r.dat <= tdo_nxt;
      tdo_r.oe <= (state_r == jtb_pkg::ST_SH_DR) ||
                  (state_r == jtb_pkg::ST_SH_IR);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // All straight from flops
  assign o_pin_out = pin_out_r;
  assign o_pin_oe = pin_oe_r;
  assign o_tdo = tdo_r;
  assign o_instr = instr_r;

endmodule // jtb_tap
